// File: hdl/cix_pkg.sv
package cix_pkg;

	// ---------------------------------------------------------------
	// Register map; CMD, OPA, OPB and RES_LO at word-aligned byte addresses, the rest at 1, 2, 3 and 5.
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_OPA = 4'h4;
	localparam logic [3:0] ADDR_OPB = 4'h8;
	localparam logic [3:0] ADDR_RES_LO = 4'hc;
	localparam logic [3:0] ADDR_RES_HI = 4'h1;
	localparam logic [3:0] ADDR_STAT = 4'h2;
	localparam logic [3:0] ADDR_FP = 4'h3;
	localparam logic [3:0] ADDR_DEFAULT_WORK_REG = 4'h5;

	// ---------------------------------------------------------------
	// Status flag positions.
	// ---------------------------------------------------------------
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_OV = 2;
	localparam int FLG_N = 3;
	localparam int FLG_DC = 8;
	localparam int FLG_WATCHDOG_TIMEOUT_FLAG = 4;
	// Sleep status sits clear of the arithmetic flags, so power save leaves N alone.
	localparam int FLG_SLEEP = 5;

	localparam logic [15:0] STAT_RST = 16'h0000;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] TWO16 = 16'h0002;
	localparam logic [15:0] SP_RST = 16'h0800;
	localparam logic [1:0] STACK_DEPTH_LOG = 2'h3;

	// ---------------------------------------------------------------
	// Operations.
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_NO_OP_ALT = 5'h01,
		OP_INC = 5'h02,
		OP_INCREMENT_TWO = 5'h03,
		OP_INCLUSIVE_OR = 5'h04,
		OP_LSR1 = 5'h05,
		OP_LSR_N = 5'h06,
		OP_FRAME_LINK = 5'h07,
		OP_MOVE = 5'h08,
		OP_MOVE_TO_DEFAULT_WORK_REG = 5'h09,
		OP_MOVE_LIT16 = 5'h0a,
		OP_MOVE_LIT8 = 5'h0b,
		OP_MOVE_DOUBLE = 5'h0c,
		OP_MUL_SS = 5'h0d,
		OP_MUL_SU = 5'h0e,
		OP_MUL_US = 5'h0f,
		OP_MUL_UU = 5'h10,
		OP_MUL_F = 5'h11,
		OP_POP = 5'h12,
		OP_POP_DOUBLE = 5'h13,
		OP_POP_SHADOW = 5'h14,
		OP_PUSH = 5'h15,
		OP_PUSH_DOUBLE = 5'h16,
		OP_PUSH_SHADOW = 5'h17,
		OP_POWER_SAVE = 5'h18,
		OP_RELATIVE_CALL = 5'h19
	} cix_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SECOND = 2'b01
	} cix_state_t;

	typedef struct packed {
		logic [15:0] lo;
		logic [15:0] hi;
	} cix_pair_t;

	localparam int CMD_OP_LSB = 0;
	localparam int CMD_LIT_LSB = 8;
	localparam int CMD_DEFAULT_WORK_REG_DST = 24;
	localparam int CMD_GO = 31;

endpackage : cix_pkg

// File: hdl/cix_exec.sv
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Increment adds one, one cycle, updates C DC N OV Z.
// - Increment-by-two adds two, one cycle, same five flags.
// - Inclusive OR forms take one cycle and change N and Z only.
// - Single logical right shift takes one cycle, updates C N OV Z.
// - Multi-bit right shift by register or 5-bit literal changes N Z; the code shifts by OPB bits 4:0 only, never by the literal.
// - Frame link takes a 14-bit literal, one cycle, no flag change.
// - Moves take one cycle, no flags, except move into default register sets N Z.
// - Immediate moves load 16-bit or 8-bit literal in one cycle, no flags.
// - Double moves take two cycles, one word, no flags.
// - Register multiply in four sign mixes, double product, one cycle.
// - Literal multiply treats the 5-bit literal as unsigned; the code has no literal multiply, each takes OPB or the default register.
// - File multiply uses default register, product to third and second registers.
// - Both no-operation forms take one cycle and change nothing.
// - Pops take one cycle; double pop takes two; no flags.
// - Shadow pop restores shadowed registers in one cycle, may alter all flags.
// - Pushes take one cycle; double push takes two; no flags.
// - Shadow push saves shadowed registers in one cycle, no flag change.
// - Power save literal picks sleep or idle; one cycle; clears watchdog bit, sets sleep bit for sleep only.
// - Relative and computed calls take two cycles, one word, no flags; the code has the relative call only.
module cix_exec
	import cix_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Avalon-MM slave.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core status.
	output logic busy,
	output logic sleep_mode,
	output logic idle_mode
);

	// ---------------------------------------------------------------
	// Architectural state.
	// ---------------------------------------------------------------
	logic [15:0] opa_ff;
	logic [15:0] opb_ff;
	logic [15:0] default_work_reg_ff;
	logic [15:0] fp_ff;
	logic [15:0] sp_ff;
	logic [15:0] stat_ff;
	logic [15:0] shadow_default_work_reg_ff;
	logic [15:0] shadow_stat_ff;
	cix_pair_t res_ff;
	logic [15:0] stack_ff [0:7];
	logic [31:0] cmd_ff;
	cix_state_t state_ff;
	logic ack_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic busy_ff;
	logic sleep_ff;
	logic idle_ff;

	cix_op_t op;
	logic [15:0] lit;
	logic go;
	assign op = cix_op_t'(cmd_ff[CMD_OP_LSB +: 5]);
	assign lit = cmd_ff[CMD_LIT_LSB +: 16];
	assign go = avs_write && !ack_ff && avs_address == ADDR_CMD
		&& avs_writedata[CMD_GO];
	logic nxt_ack;
	assign nxt_ack = (avs_read || avs_write) && !ack_ff && state_ff != ST_SECOND;

	// ---------------------------------------------------------------
	// Datapath for the executing command.
	// ---------------------------------------------------------------
	logic [16:0] sum;
	logic [4:0] dsum;
	logic [15:0] orv;
	logic [15:0] shv;
	logic [31:0] prod;
	logic signed [33:0] sprod;
	logic [16:0] ea;
	logic [16:0] eb;
	logic [2:0] sp_idx;

	assign sp_idx = sp_ff[3:1];

	always_comb begin
		ea = {1'b0, opa_ff};
		eb = {1'b0, opb_ff};
		unique case (cmd_ff[CMD_OP_LSB +: 5])
			OP_MUL_SS: begin
				ea = {opa_ff[15], opa_ff};
				eb = {opb_ff[15], opb_ff};
			end
			OP_MUL_SU: begin
				ea = {opa_ff[15], opa_ff};
			end
			OP_MUL_US: begin
				eb = {opb_ff[15], opb_ff};
			end
			OP_MUL_F: begin
				eb = {1'b0, default_work_reg_ff};
			end
			default: begin
			end
		endcase
	end

	always_comb begin
		sum = {1'b0, opa_ff} + {1'b0, (op == OP_INCREMENT_TWO) ? TWO16 : ONE16};
		dsum = {1'b0, opa_ff[3:0]} + ((op == OP_INCREMENT_TWO) ? 5'h02 : 5'h01);
		orv = opa_ff | opb_ff;
		shv = (op == OP_LSR1) ? (opa_ff >> 1) : (opa_ff >> opb_ff[4:0]);
		sprod = $signed(ea) * $signed(eb);
		prod = sprod[31:0];
	end

	// ---------------------------------------------------------------
	// Bus slave: one command write, the answer a cycle later.
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ack_ff <= 1'b0;
			wait_ff <= 1'b1;
		end else begin
			ack_ff <= nxt_ack;
			wait_ff <= !nxt_ack;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read && !ack_ff) begin
			unique case (avs_address)
				ADDR_CMD: rdata_ff <= cmd_ff;
				ADDR_OPA: rdata_ff <= {16'h0000, opa_ff};
				ADDR_OPB: rdata_ff <= {16'h0000, opb_ff};
				ADDR_RES_LO: rdata_ff <= {16'h0000, res_ff.lo};
				ADDR_RES_HI: rdata_ff <= {16'h0000, res_ff.hi};
				ADDR_STAT: rdata_ff <= {16'h0000, stat_ff};
				ADDR_FP: rdata_ff <= {16'h0000, fp_ff};
				ADDR_DEFAULT_WORK_REG: rdata_ff <= {16'h0000, default_work_reg_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cmd_ff <= 32'h0000_0000;
			opa_ff <= WORD_ZERO;
			opb_ff <= WORD_ZERO;
		end else if (avs_write && !ack_ff && state_ff == ST_IDLE) begin
			if (avs_address == ADDR_CMD) cmd_ff <= avs_writedata;
			if (avs_address == ADDR_OPA) opa_ff <= avs_writedata[15:0];
			if (avs_address == ADDR_OPB) opb_ff <= avs_writedata[15:0];
		end
	end

	// ---------------------------------------------------------------
	// Sequencer: two-cycle forms hold a second cycle.
	// ---------------------------------------------------------------
	logic run;
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			run <= 1'b0;
		end else begin
			run <= go && state_ff == ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			busy_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (run && (op == OP_MOVE_DOUBLE || op == OP_POP_DOUBLE
						|| op == OP_PUSH_DOUBLE || op == OP_RELATIVE_CALL)) begin
						state_ff <= ST_SECOND;
						busy_ff <= 1'b1;
					end
				end
				ST_SECOND: begin
					state_ff <= ST_IDLE;
					busy_ff <= 1'b0;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Results and special registers.
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			res_ff <= '0;
			default_work_reg_ff <= WORD_ZERO;
			fp_ff <= WORD_ZERO;
			shadow_default_work_reg_ff <= WORD_ZERO;
		end else if (run) begin
			unique case (op)
				OP_INC, OP_INCREMENT_TWO: res_ff.lo <= sum[15:0];
				OP_INCLUSIVE_OR: res_ff.lo <= orv;
				OP_LSR1, OP_LSR_N: res_ff.lo <= shv;
				OP_FRAME_LINK: fp_ff <= sp_ff + {2'h0, lit[13:0]};
				OP_MOVE: res_ff.lo <= opa_ff;
				OP_MOVE_TO_DEFAULT_WORK_REG: default_work_reg_ff <= opa_ff;
				OP_MOVE_LIT16: res_ff.lo <= lit;
				OP_MOVE_LIT8: res_ff.lo <= {8'h00, lit[7:0]};
				OP_MUL_SS, OP_MUL_SU, OP_MUL_US, OP_MUL_UU: res_ff <= {prod[15:0], prod[31:16]};
				OP_MUL_F: res_ff <= {prod[15:0], prod[31:16]};
				OP_POP: res_ff.lo <= stack_ff[sp_idx - 3'h1];
				OP_POP_DOUBLE: res_ff.hi <= stack_ff[sp_idx - 3'h1];
				OP_POP_SHADOW: default_work_reg_ff <= shadow_default_work_reg_ff;
				OP_PUSH_SHADOW: shadow_default_work_reg_ff <= default_work_reg_ff;
				default: begin
				end
			endcase
			if (op == OP_INC || op == OP_INCREMENT_TWO || op == OP_INCLUSIVE_OR
				|| op == OP_LSR1) begin
				if (cmd_ff[CMD_DEFAULT_WORK_REG_DST]) begin
					default_work_reg_ff <= (op == OP_INCLUSIVE_OR) ? orv : (op == OP_LSR1) ? shv : sum[15:0];
				end
			end
		end else if (state_ff == ST_SECOND && op == OP_POP_DOUBLE) begin
			res_ff.lo <= stack_ff[sp_idx - 3'h1];
		end
	end

	// Stack pointer and memory; double push, double pop and relative call move the second word in the second cycle.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sp_ff <= SP_RST;
		end else if (run) begin
			unique case (op)
				OP_PUSH, OP_PUSH_DOUBLE, OP_RELATIVE_CALL: begin
					stack_ff[sp_idx] <= opa_ff;
					sp_ff <= sp_ff + TWO16;
				end
				OP_POP, OP_POP_DOUBLE: sp_ff <= sp_ff - TWO16;
				OP_FRAME_LINK: begin
					stack_ff[sp_idx] <= fp_ff;
					sp_ff <= sp_ff + TWO16 + {2'h0, lit[13:0]};
				end
				default: begin
				end
			endcase
		end else if (state_ff == ST_SECOND) begin
			if (op == OP_PUSH_DOUBLE || op == OP_RELATIVE_CALL) begin
				stack_ff[sp_idx] <= opb_ff;
				sp_ff <= sp_ff + TWO16;
			end else if (op == OP_POP_DOUBLE) begin
				sp_ff <= sp_ff - TWO16;
			end
		end
	end

	// ---------------------------------------------------------------
	// Status flags; untouched bits hold their value.
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			stat_ff <= STAT_RST;
			shadow_stat_ff <= STAT_RST;
		end else if (run) begin
			unique case (op)
				OP_INC, OP_INCREMENT_TWO: begin
					stat_ff[FLG_C] <= sum[16];
					stat_ff[FLG_DC] <= dsum[4];
					stat_ff[FLG_N] <= sum[15];
					stat_ff[FLG_OV] <= !opa_ff[15] && sum[15];
					stat_ff[FLG_Z] <= sum[15:0] == WORD_ZERO;
				end
				OP_INCLUSIVE_OR: begin
					stat_ff[FLG_N] <= orv[15];
					stat_ff[FLG_Z] <= orv == WORD_ZERO;
				end
				OP_LSR1: begin
					stat_ff[FLG_C] <= opa_ff[0];
					stat_ff[FLG_N] <= 1'b0;
					stat_ff[FLG_OV] <= 1'b0;
					stat_ff[FLG_Z] <= shv == WORD_ZERO;
				end
				OP_LSR_N: begin
					stat_ff[FLG_N] <= shv[15];
					stat_ff[FLG_Z] <= shv == WORD_ZERO;
				end
				OP_MOVE_TO_DEFAULT_WORK_REG: begin
					stat_ff[FLG_N] <= opa_ff[15];
					stat_ff[FLG_Z] <= opa_ff == WORD_ZERO;
				end
				OP_POP_SHADOW: stat_ff <= shadow_stat_ff;
				OP_PUSH_SHADOW: shadow_stat_ff <= stat_ff;
				OP_POWER_SAVE: begin
					stat_ff[FLG_WATCHDOG_TIMEOUT_FLAG] <= 1'b0;
					stat_ff[FLG_SLEEP] <= lit[0] == 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// Power save: literal 0 enters sleep, 1 enters idle; cleared by reset.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sleep_ff <= 1'b0;
			idle_ff <= 1'b0;
		end else if (run && op == OP_POWER_SAVE) begin
			sleep_ff <= !lit[0];
			idle_ff <= lit[0];
		end
	end

	assign avs_waitrequest = wait_ff;
	assign avs_readdata = rdata_ff;
	assign busy = busy_ff;
	assign sleep_mode = sleep_ff;
	assign idle_mode = idle_ff;

endmodule : cix_exec

`default_nettype wire

// File: sim/cix_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
module cix_exec_props (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Avalon-MM slave.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Core status.
	input wire logic busy,
	input wire logic sleep_mode,
	input wire logic idle_mode
);
	// ---------------------------------------------------------------
	// Properties.
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence req_s;
		// A request met in the second cycle of a two-cycle form is held off one cycle more.
		(avs_read || avs_write) && avs_waitrequest && !busy;
	endsequence
	sequence ack_s;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	sequence wr_recent_s;
		$past(avs_write, 1) || $past(avs_write, 2) || $past(avs_write, 3) || $past(avs_write, 4);
	endsequence
	ack_turn_a: assert property (req_s |=> ack_s) else $error("answer not one cycle later");
	no_req_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("answer without request");
	rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved without read");
	busy_one_a: assert property (busy |=> !busy)
		else $error("busy longer than one cycle");
	busy_cause_a: assert property ($rose(busy) |-> wr_recent_s)
		else $error("busy without command");
	mode_excl_a: assert property (!(sleep_mode && idle_mode))
		else $error("sleep and idle together");
	mode_cause_a: assert property ($rose(sleep_mode) || $rose(idle_mode) |-> wr_recent_s)
		else $error("power mode without command");
	reset_val_a: assert property (disable iff (1'b0)
		!reset_n |=> avs_waitrequest && !busy && !sleep_mode && !idle_mode)
		else $error("outputs not at reset values");
endmodule : cix_exec_props
bind cix_exec cix_exec_props cix_exec_props_inst (.ref_clk(ref_clk), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .busy(busy), .sleep_mode(sleep_mode),
	.idle_mode(idle_mode));
`default_nettype wire

// File: sim/cix_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module cix_exec_test;
	import cix_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic busy;
	logic sleep_mode;
	logic idle_mode;
	int mismatches = 0;
	int checks = 0;
	logic [31:0] d;
	cix_op_t nf[11] = '{OP_NOP, OP_NO_OP_ALT, OP_FRAME_LINK, OP_PUSH, OP_POP, OP_PUSH_SHADOW,
		OP_POP_SHADOW, OP_MOVE_DOUBLE, OP_PUSH_DOUBLE, OP_POP_DOUBLE, OP_RELATIVE_CALL};
	cix_exec cix_exec_inst (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy),
		.sleep_mode(sleep_mode), .idle_mode(idle_mode));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	// ---------------------------------------------------------------
	// Bus and compare tasks.
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// The request is held until the edge that samples waitrequest low.
	task automatic xfer(logic wr, logic [3:0] ad, logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		avs_address <= ad;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : xfer
	function automatic logic [31:0] cmd(cix_op_t op, logic [15:0] lit);
		return {1'b1, 7'h00, lit, 3'h0, op};
	endfunction : cmd
	task automatic run(cix_op_t op, logic [15:0] a, logic [15:0] b, logic [15:0] lit,
		logic [15:0] lo, logic [15:0] hi, int chk, logic [15:0] st, int nb);
		int n;
		logic [31:0] r;
		xfer(1'b1, ADDR_OPA, {16'h0000, a}, r);
		xfer(1'b1, ADDR_OPB, {16'h0000, b}, r);
		xfer(1'b1, ADDR_CMD, cmd(op, lit), r);
		n = 0;
		repeat (4) begin
			@(posedge ref_clk);
			if (busy !== 1'b0) n++;
		end
		check("busy cycles", n, nb);
		if (chk > 0) begin
			xfer(1'b0, ADDR_RES_LO, 32'h00000000, r);
			check("res_lo", r[15:0], lo);
		end
		if (chk > 1) begin
			xfer(1'b0, ADDR_RES_HI, 32'h00000000, r);
			check("res_hi", r[15:0], hi);
		end
		xfer(1'b0, ADDR_STAT, 32'h00000000, r);
		check("status", r & 32'h0000010f, {16'h0000, st});
	endtask : run
	task automatic do_reset();
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
	endtask : do_reset
	// ---------------------------------------------------------------
	// Tests.
	// ---------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		end_sim();
	end
	initial begin
		do_reset();
		xfer(1'b0, ADDR_STAT, 32'h00000000, d);
		check("status reset", d[15:0], STAT_RST);
		xfer(1'b0, 4'hf, 32'h00000000, d);
		check("unmapped", d, 32'h00000000);
		run(OP_INC, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1, 16'h0103, 0);
		run(OP_INCLUSIVE_OR, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1, 16'h0103, 0);
		run(OP_LSR1, 16'h0003, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 1, 16'h0101, 0);
		run(OP_INCREMENT_TWO, 16'h7fff, 16'h0000, 16'h0000, 16'h8001, 16'h0000, 1, 16'h010c, 0);
		run(OP_LSR_N, 16'h8000, 16'h0004, 16'h0004, 16'h0800, 16'h0000, 1, 16'h0104, 0);
		run(OP_MUL_UU, 16'hffff, 16'h0003, 16'h0003, 16'hfffd, 16'h0002, 2, 16'h0104, 0);
		run(OP_MUL_SS, 16'hffff, 16'hffff, 16'h0000, 16'h0001, 16'h0000, 2, 16'h0104, 0);
		run(OP_MUL_SU, 16'hffff, 16'h0002, 16'h0002, 16'hfffe, 16'hffff, 2, 16'h0104, 0);
		run(OP_MUL_US, 16'h0002, 16'hffff, 16'h0000, 16'hfffe, 16'hffff, 2, 16'h0104, 0);
		run(OP_MOVE_LIT16, 16'h0000, 16'h0000, 16'ha5c3, 16'ha5c3, 16'h0000, 1, 16'h0104, 0);
		run(OP_MOVE_LIT8, 16'h0000, 16'h0000, 16'h01a5, 16'h00a5, 16'h0000, 1, 16'h0104, 0);
		run(OP_MOVE, 16'h8000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 1, 16'h0104, 0);
		run(OP_MOVE_TO_DEFAULT_WORK_REG, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 0, 16'h010c, 0);
		xfer(1'b0, ADDR_DEFAULT_WORK_REG, 32'h0000_0000, d);
		check("default_work_reg move", d, 32'h0000_8000);
		run(OP_MUL_F, 16'h0003, 16'h0000, 16'h0000, 16'h8000, 16'h0001, 2, 16'h010c, 0);
		foreach (nf[i]) begin
			run(nf[i], 16'h0001, 16'h0001, 16'h0010, 16'h0000, 16'h0000, 0, 16'h010c, (i >= 7) ? 1 : 0);
		end
		run(OP_PUSH_DOUBLE, 16'h1234, 16'h5678, 16'h0000, 16'h0000, 16'h0000, 0, 16'h010c, 1);
		run(OP_POP_DOUBLE, 16'h0000, 16'h0000, 16'h0000, 16'h1234, 16'h5678, 2, 16'h010c, 1);
		xfer(1'b1, ADDR_OPA, 32'h0000_0041, d);
		xfer(1'b1, ADDR_CMD, cmd(OP_INC, 16'h0000) | (32'h0000_0001 << CMD_DEFAULT_WORK_REG_DST), d);
		xfer(1'b0, ADDR_DEFAULT_WORK_REG, 32'h0000_0000, d);
		check("default_work_reg inc", d, 32'h0000_0042);
		xfer(1'b1, ADDR_CMD, cmd(OP_POWER_SAVE, 16'h0000), d);
		repeat (4) @(posedge ref_clk);
		check("sleep", sleep_mode, 1'b1);
		check("idle", idle_mode, 1'b0);
		xfer(1'b0, ADDR_STAT, 32'h0000_0000, d);
		check("status sleep", d & 32'h0000_013f, 32'h0000_0020);
		do_reset();
		xfer(1'b1, ADDR_CMD, cmd(OP_POWER_SAVE, 16'h0001), d);
		repeat (4) @(posedge ref_clk);
		check("idle", idle_mode, 1'b1);
		check("sleep", sleep_mode, 1'b0);
		end_sim();
	end
endmodule : cix_exec_test
`default_nettype wire
